// ---- hdl/ots_map.vh ----
`ifndef OTS_MAP_VH
`define OTS_MAP_VH

// ==========================================================================
// register byte offsets
`define OTS_CTRL_OFS 8'h00
`define OTS_CHSEL_OFS 8'h04
`define OTS_OFFSET_OFS 8'h08
`define OTS_MAXLAT_OFS 8'h0C
`define OTS_STATUS_OFS 8'h10
`define OTS_CMD_OFS 8'h14
`define OTS_ONDLY_BASE 8'h20
`define OTS_OFFDLY_BASE 8'h30
`define OTS_MODCFG_BASE 8'h40

// ==========================================================================
// field positions
`define OTS_CTRL_EN_BIT 0
`define OTS_CMD_ON_LSB 0
`define OTS_CMD_OFF_LSB 4
`define OTS_CFG_CLASS_LSB 0
`define OTS_CFG_RELAY_BIT 2
`define OTS_CFG_CPRI_BIT 3
`define OTS_CFG_INST_BIT 4
`define OTS_STAT_BUSY_LSB 4

// ==========================================================================
// reset values
`define OTS_CTRL_RST 1'b0
`define OTS_CHSEL_RST 4'h0
`define OTS_DLY_RST 16'h0000
`define OTS_CFG_RST 5'h00

// ==========================================================================
// timing: clock period and time-base tick, both in ns
`define OTS_CLK_NS 8
`define OTS_TICK_NS 1000000
`define OTS_SYNC_PULSE_CYC 16

// inherent module latencies in ms
`define OTS_LAT_STD_MS 16'd32
`define OTS_LAT_STD_RLY_MS 16'd58
`define OTS_LAT_MID_MS 16'd25
`define OTS_LAT_MID_RLY_MS 16'd51
`define OTS_LAT_FAST_MS 16'd18
`define OTS_LAT_FAST_RLY_MS 16'd44
`define OTS_LAT_CPRI_MS 16'd23
`define OTS_LAT_CPRI_RLY_MS 16'd45

`endif

// ---- hdl/ots_chan.v ----
`timescale 1ns/10ps
`include "ots_map.vh"

module ots_chan #(
  parameter DW = 16
) (
  input wire sys_clk_i,
  input wire arst_n_i,
  input wire tick_i,
  input wire on_evt_i,
  input wire off_evt_i,
  input wire [DW-1:0] first_i,
  input wire [DW-1:0] on_dly_i,
  input wire [DW-1:0] off_dly_i,
  output reg out_on_o,
  output wire busy_o
);

  localparam ST_IDLE = 2'd0;
  localparam ST_FIRST = 2'd1;
  localparam ST_DLY = 2'd2;
  localparam ST_OFFW = 2'd3;

  reg [1:0] state_reg;
  reg [DW-1:0] cnt_reg;

  assign busy_o = (state_reg != ST_IDLE);

  // ========================================================================
  // delay sequencer, counts whole time-base ticks
  always @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= {DW{1'b0}};
      out_on_o <= 1'b0;
    end
    else if (off_evt_i)
    begin
      // off starts its own delay at once, aborting any pending turn-on
      state_reg <= ST_OFFW;
      cnt_reg <= off_dly_i;
    end
    else if (on_evt_i)
    begin
      state_reg <= ST_FIRST;
      cnt_reg <= first_i;
    end
    else
    begin
      case (state_reg)
        ST_FIRST:
        begin
          if (cnt_reg == {DW{1'b0}})
          begin
            state_reg <= ST_DLY;
            cnt_reg <= on_dly_i;
          end
          else if (tick_i)
            cnt_reg <= cnt_reg - 1'b1;
        end
        ST_DLY:
        begin
          if (cnt_reg == {DW{1'b0}})
          begin
            out_on_o <= 1'b1;
            state_reg <= ST_IDLE;
          end
          else if (tick_i)
            cnt_reg <= cnt_reg - 1'b1;
        end
        ST_OFFW:
        begin
          if (cnt_reg == {DW{1'b0}})
          begin
            out_on_o <= 1'b0;
            state_reg <= ST_IDLE;
          end
          else if (tick_i)
            cnt_reg <= cnt_reg - 1'b1;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule // ots_chan

// ---- hdl/ots_sline.v ----
`timescale 1ns/10ps
`include "ots_map.vh"

module ots_sline #(
  parameter PULSE = `OTS_SYNC_PULSE_CYC
) (
  input wire sys_clk_i,
  input wire arst_n_i,
  input wire fire_i,
  input wire line_i,
  output wire line_o,
  output reg line_oe_o,
  output wire fall_o
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  reg [7:0] pcnt_reg;

  // open-drain: only ever pulls low
  assign line_o = 1'b0;
  // our own pulse is already acted on locally, so its echo is ignored
  assign fall_o = s3_reg & ~s2_reg & ~line_oe_o;

  // ========================================================================
  // synchroniser, echo guard and drive pulse
  always @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      pcnt_reg <= 8'h00;
      line_oe_o <= 1'b0;
    end
    else
    begin
      s1_reg <= line_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (fire_i)
      begin
        line_oe_o <= 1'b1;
        pcnt_reg <= PULSE[7:0];
      end
      else if (pcnt_reg != 8'h00)
        pcnt_reg <= pcnt_reg - 8'h01;
      else
        line_oe_o <= 1'b0;
    end
  end

endmodule // ots_sline

// ---- hdl/ots_seq.v ----
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`include "ots_map.vh"

// Overview of operation
// - an off request starts each channel's turn-off delay at once, no offset.
// - without offset, turn-on time is inherent latency plus programmed delay.
// - inherent latency set by module class and relay: 32/58, 25/51, 18/44 ms.
// - current-priority modules have 23 ms latency, 45 ms with relays; the code honours this in class 3 only.
// - with an offset, each coupled channel's delay starts after the offset from the on event.
// - software enables or disables coupling for the whole frame.
// - software selects which of four channels are coupled.
// - every channel accepts any independent turn-on delay and any order.
// - one common offset value held for the whole frame.
// - a read returns the largest inherent latency of installed modules.
// - while enabled, on or off on any coupled channel switches all coupled.
// - sync lines are open-drain both ways; a falling edge is the event.
module ots_seq #(
  parameter NCH = 4,
  parameter DW = 16,
  parameter TICK_CYCLES = `OTS_TICK_NS / `OTS_CLK_NS
) (
  input wire sys_clk_i,
  input wire arst_n_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire sync_on_line_i,
  output wire sync_on_line_o,
  output wire sync_on_line_oe_o,
  input wire sync_off_line_i,
  output wire sync_off_line_o,
  output wire sync_off_line_oe_o,
  output wire [NCH-1:0] chan_on_o
);

  reg sync_enable_reg;
  reg [NCH-1:0] chsel_reg;
  reg [DW-1:0] offset_reg;
  reg [DW*NCH-1:0] on_dly_reg;
  reg [DW*NCH-1:0] off_dly_reg;
  reg [5*NCH-1:0] cfg_reg;
  reg [23:0] tick_cnt_reg;
  reg tick_reg;
  reg [DW-1:0] max_lat;
  reg [31:0] rd_next;
  wire [DW*NCH-1:0] lat;
  wire [DW*NCH-1:0] first;
  wire [NCH-1:0] busy;
  wire [NCH-1:0] on_evt;
  wire [NCH-1:0] off_evt;
  wire [NCH-1:0] coupled;
  wire cmd_wr;
  wire [NCH-1:0] req_on;
  wire [NCH-1:0] req_off;
  wire loc_on_hit;
  wire loc_off_hit;
  wire on_fall;
  wire off_fall;
  wire grp_on;
  wire grp_off;
  integer i;
  integer j;
  integer n;
  genvar g;

  // ========================================================================
  // inherent latency lookup
  function [DW-1:0] lat_of;
    input [4:0] cfg;
    begin
      case (cfg[1:0])
        2'd1:
          lat_of = cfg[`OTS_CFG_RELAY_BIT] ? `OTS_LAT_MID_RLY_MS
                                           : `OTS_LAT_MID_MS;
        2'd2:
          lat_of = cfg[`OTS_CFG_RELAY_BIT] ? `OTS_LAT_FAST_RLY_MS
                                           : `OTS_LAT_FAST_MS;
        2'd3:
          if (cfg[`OTS_CFG_CPRI_BIT])
            lat_of = cfg[`OTS_CFG_RELAY_BIT] ? `OTS_LAT_CPRI_RLY_MS
                                             : `OTS_LAT_CPRI_MS;
          else
            lat_of = cfg[`OTS_CFG_RELAY_BIT] ? `OTS_LAT_STD_RLY_MS
                                             : `OTS_LAT_STD_MS;
        default:
          lat_of = cfg[`OTS_CFG_RELAY_BIT] ? `OTS_LAT_STD_RLY_MS
                                           : `OTS_LAT_STD_MS;
      endcase
    end
  endfunction

  // ========================================================================
  // shared time base
  always @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tick_cnt_reg <= 24'h000000;
      tick_reg <= 1'b0;
    end
    else if (tick_cnt_reg == TICK_CYCLES[23:0] - 24'h000001)
    begin
      tick_cnt_reg <= 24'h000000;
      tick_reg <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 24'h000001;
      tick_reg <= 1'b0;
    end
  end

  // ========================================================================
  // register writes
  always @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sync_enable_reg <= `OTS_CTRL_RST;
      chsel_reg <= `OTS_CHSEL_RST;
      offset_reg <= `OTS_DLY_RST;
      on_dly_reg <= {NCH{`OTS_DLY_RST}};
      off_dly_reg <= {NCH{`OTS_DLY_RST}};
      cfg_reg <= {NCH{`OTS_CFG_RST}};
    end
    else if (wr_i)
    begin
      if (addr_i == `OTS_CTRL_OFS)
        sync_enable_reg <= wdata_i[`OTS_CTRL_EN_BIT];
      if (addr_i == `OTS_CHSEL_OFS)
        chsel_reg <= wdata_i[NCH-1:0];
      // any value is taken, even below the largest latency
      if (addr_i == `OTS_OFFSET_OFS)
        offset_reg <= wdata_i[DW-1:0];
      for (i = 0; i < NCH; i = i + 1)
      begin
        if (addr_i == `OTS_ONDLY_BASE + 4 * i)
          on_dly_reg[i*DW +: DW] <= wdata_i[DW-1:0];
        if (addr_i == `OTS_OFFDLY_BASE + 4 * i)
          off_dly_reg[i*DW +: DW] <= wdata_i[DW-1:0];
        if (addr_i == `OTS_MODCFG_BASE + 4 * i)
          cfg_reg[i*5 +: 5] <= wdata_i[4:0];
      end
    end
  end

  // ========================================================================
  // on/off requests and coupling
  assign cmd_wr = wr_i & (addr_i == `OTS_CMD_OFS);
  assign req_on = cmd_wr ? wdata_i[`OTS_CMD_ON_LSB +: NCH] : {NCH{1'b0}};
  assign req_off = cmd_wr ? wdata_i[`OTS_CMD_OFF_LSB +: NCH] : {NCH{1'b0}};
  assign coupled = sync_enable_reg ? chsel_reg : {NCH{1'b0}};
  assign loc_on_hit = |(req_on & coupled);
  assign loc_off_hit = |(req_off & coupled);
  assign grp_on = loc_on_hit | (sync_enable_reg & on_fall);
  assign grp_off = loc_off_hit | (sync_enable_reg & off_fall);
  // off beats on when both arrive together
  assign off_evt = (req_off & ~coupled) | (grp_off ? coupled : {NCH{1'b0}});
  assign on_evt = (req_on & ~coupled) | (grp_on ? coupled : {NCH{1'b0}});

  ots_sline u_on_line (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .fire_i(loc_on_hit),
    .line_i(sync_on_line_i),
    .line_o(sync_on_line_o),
    .line_oe_o(sync_on_line_oe_o),
    .fall_o(on_fall)
  );

  ots_sline u_off_line (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .fire_i(loc_off_hit),
    .line_i(sync_off_line_i),
    .line_o(sync_off_line_o),
    .line_oe_o(sync_off_line_oe_o),
    .fall_o(off_fall)
  );

  // ========================================================================
  // per-channel sequencers
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_ch
      assign lat[g*DW +: DW] = lat_of(cfg_reg[g*5 +: 5]);
      // zero offset falls back to the module's own latency
      assign first[g*DW +: DW] =
        (coupled[g] && offset_reg != {DW{1'b0}}) ? offset_reg
                                                 : lat[g*DW +: DW];
      ots_chan #(.DW(DW)) u_chan (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .tick_i(tick_reg),
        .on_evt_i(on_evt[g]),
        .off_evt_i(off_evt[g]),
        .first_i(first[g*DW +: DW]),
        .on_dly_i(on_dly_reg[g*DW +: DW]),
        .off_dly_i(off_dly_reg[g*DW +: DW]),
        .out_on_o(chan_on_o[g]),
        .busy_o(busy[g])
      );
    end
  endgenerate

  // ========================================================================
  // largest latency among installed modules
  always @*
  begin
    max_lat = {DW{1'b0}};
    // own loop index: a shared one would wake the other processes
    for (j = 0; j < NCH; j = j + 1)
      if (cfg_reg[j*5 + `OTS_CFG_INST_BIT] && lat[j*DW +: DW] > max_lat)
        max_lat = lat[j*DW +: DW];
  end

  // ========================================================================
  // read mux, data one cycle after the strobe
  always @*
  begin
    rd_next = 32'h00000000;
    case (addr_i)
      `OTS_CTRL_OFS: rd_next[0] = sync_enable_reg;
      `OTS_CHSEL_OFS: rd_next[NCH-1:0] = chsel_reg;
      `OTS_OFFSET_OFS: rd_next[DW-1:0] = offset_reg;
      `OTS_MAXLAT_OFS: rd_next[DW-1:0] = max_lat;
      `OTS_STATUS_OFS:
      begin
        rd_next[NCH-1:0] = chan_on_o;
        rd_next[`OTS_STAT_BUSY_LSB +: NCH] = busy;
      end
      default:
        for (n = 0; n < NCH; n = n + 1)
        begin
          if (addr_i == `OTS_ONDLY_BASE + 4 * n)
            rd_next[DW-1:0] = on_dly_reg[n*DW +: DW];
          if (addr_i == `OTS_OFFDLY_BASE + 4 * n)
            rd_next[DW-1:0] = off_dly_reg[n*DW +: DW];
          if (addr_i == `OTS_MODCFG_BASE + 4 * n)
            rd_next[4:0] = cfg_reg[n*5 +: 5];
        end
    endcase
  end

  always @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata_o <= 32'h00000000;
    else if (rd_i)
      rdata_o <= rd_next;
    else
      rdata_o <= 32'h00000000;
  end

endmodule // ots_seq

// ---- bench/ots_seq_assertions.sv ----
`timescale 1ns/10ps
module ots_seq_chk #(
  parameter NCH = 4,
  parameter DW = 16,
  parameter TICK_CYCLES = 4
) (
  input wire sys_clk_i,
  input wire arst_n_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire sync_on_line_i,
  input wire sync_on_line_o,
  input wire sync_on_line_oe_o,
  input wire sync_off_line_i,
  input wire sync_off_line_o,
  input wire sync_off_line_oe_o,
  input wire [NCH-1:0] chan_on_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // ==========================================================
  // register port
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside read cycle");
  a_cmd_rd_zero: assert property ($past(rd_i) && $past(addr_i) == 8'h14
    |-> rdata_o == 32'h0) else $error("command register not write only");
  a_status_echo: assert property ($past(rd_i) && $past(addr_i) == 8'h10
    |-> rdata_o[NCH-1:0] == $past(chan_on_o)) else $error("status mismatch");
  a_maxlat_width: assert property ($past(rd_i) && $past(addr_i) == 8'h0C
    |-> rdata_o[31:16] == 16'h0) else $error("latency upper bits set");
  // ==========================================================
  // sync lines: open drain, 17 cycle pulse after a command write
  a_line_low: assert property (!sync_on_line_o && !sync_off_line_o)
    else $error("sync line driven high");
  a_on_pulse: assert property ($rose(sync_on_line_oe_o) |->
    sync_on_line_oe_o [*8] ##1 sync_on_line_oe_o [*8] ##1 sync_on_line_oe_o
    ##1 !sync_on_line_oe_o) else $error("on pulse");
  a_off_pulse: assert property ($rose(sync_off_line_oe_o) |->
    sync_off_line_oe_o [*8] ##1 sync_off_line_oe_o [*8] ##1 sync_off_line_oe_o
    ##1 !sync_off_line_oe_o) else $error("off pulse");
  a_on_cause: assert property ($rose(sync_on_line_oe_o) |->
    ($past(wr_i) && $past(addr_i) == 8'h14)
    || ($past(wr_i, 2) && $past(addr_i, 2) == 8'h14))
    else $error("on pulse without command");
  c_coupled_on: cover property ($rose(sync_on_line_oe_o));
  c_remote_off: cover property ($fell(sync_off_line_i) && !sync_off_line_oe_o);
  c_two_on: cover property (chan_on_o[1:0] == 2'b11);
endmodule // ots_seq_chk

bind ots_seq ots_seq_chk #(.NCH(NCH), .DW(DW), .TICK_CYCLES(TICK_CYCLES))
  u_ots_seq_chk (.sys_clk_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .sync_on_line_i, .sync_on_line_o, .sync_on_line_oe_o,
  .sync_off_line_i, .sync_off_line_o, .sync_off_line_oe_o, .chan_on_o);

// ---- bench/ots_frame_model.sv ----
`timescale 1ns/10ps
// ==========================================================
// second frame on the shared sync lines
module ots_frame_model (
  input wire sys_clk_i,
  input wire dut_on_oe_i,
  input wire dut_off_oe_i,
  input wire pull_off_i,
  output wire on_line_o,
  output wire off_line_o,
  output reg [7:0] on_falls_o
);
  reg [4:0] hold_reg;
  reg on_q;
  // pull-up lines: low while any party pulls
  assign on_line_o = ~dut_on_oe_i;
  assign off_line_o = ~(dut_off_oe_i | (hold_reg != 5'h0));
  initial
  begin
    hold_reg = 5'h0;
    on_q = 1'b1;
    on_falls_o = 8'h0;
  end
  always @(posedge sys_clk_i)
  begin
    on_q <= on_line_o;
    if (on_q && !on_line_o)
      on_falls_o <= on_falls_o + 8'h1;
    if (pull_off_i)
      hold_reg <= 5'h11;
    else if (hold_reg != 5'h0)
      hold_reg <= hold_reg - 5'h1;
  end
endmodule // ots_frame_model

// ---- bench/testbench.sv ----
`timescale 1ns/10ps
`include "ots_map.vh"
module testbench;
  localparam TK = 4;
  // cfg codes and latencies in ms, entry k at k*5 and k*8
  localparam [39:0] CFGS = {5'h0F, 5'h0B, 5'h06, 5'h02, 5'h05, 5'h01,
    5'h04, 5'h00};
  localparam [63:0] LATS = {8'h2D, 8'h17, 8'h2C, 8'h12, 8'h33, 8'h19,
    8'h3A, 8'h20};
  reg sys_clk_i, arst_n_i, wr_i, rd_i, pull_off;
  reg [7:0] addr_i;
  reg [31:0] wdata_i;
  wire [31:0] rdata_o;
  wire on_ln, off_ln, on_oe, off_oe;
  wire [3:0] chan_on;
  wire [7:0] on_falls;
  integer failures, check_count, cyc, t0, k;
  ots_seq #(.NCH(4), .DW(16), .TICK_CYCLES(TK)) u_ots_seq (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sync_on_line_i(on_ln), .sync_on_line_o(), .sync_on_line_oe_o(on_oe),
    .sync_off_line_i(off_ln), .sync_off_line_o(),
    .sync_off_line_oe_o(off_oe), .chan_on_o(chan_on));
  ots_frame_model u_ots_frame_model (.sys_clk_i(sys_clk_i),
    .dut_on_oe_i(on_oe), .dut_off_oe_i(off_oe), .pull_off_i(pull_off),
    .on_line_o(on_ln), .off_line_o(off_ln), .on_falls_o(on_falls));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  task finish_test;
  begin
    $display("checks %0d errors %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  // ==========================================================
  // timeout: whole run needs well under 1500 cycles
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc > 3000)
    begin
      failures = failures + 1;
      finish_test;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  end
  endtask
  task rd(input [7:0] a, input [31:0] exp);
  begin
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  end
  endtask
  // channel must still be at ~v one tick early, at v within 3 ticks late
  task at_tick(input integer ch, input v, input integer n);
  begin
    while (cyc < t0 + (n - 1) * TK) @(posedge sys_clk_i);
    #1 chk(chan_on[ch], !v);
    while (chan_on[ch] !== v && cyc < t0 + (n + 3) * TK)
      @(posedge sys_clk_i);
    #1 chk(chan_on[ch], v);
  end
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    arst_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    pull_off = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    failures = 0;
    check_count = 0;
    cyc = 0;
    repeat (2) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    rd(`OTS_CTRL_OFS, 32'h0);
    rd(`OTS_CHSEL_OFS, 32'h0);
    rd(`OTS_OFFSET_OFS, 32'h0);
    rd(`OTS_MAXLAT_OFS, 32'h0);
    rd(8'h80, 32'h0);
    rd(`OTS_CMD_OFS, 32'h0);
    for (k = 0; k < 8; k = k + 1)
    begin
      wr(`OTS_MODCFG_BASE, {27'h0, CFGS[k*5+:5] | 5'h10});
      rd(`OTS_MAXLAT_OFS, {24'h0, LATS[k*8+:8]});
    end
    wr(`OTS_MODCFG_BASE, 32'h12);
    wr(`OTS_MODCFG_BASE + 8'h04, 32'h11);
    wr(`OTS_MODCFG_BASE + 8'h08, 32'h10);
    rd(`OTS_MAXLAT_OFS, 32'h20);
    // coupling off: own channel only, latency 18 plus 2
    wr(`OTS_ONDLY_BASE, 32'h2);
    wr(`OTS_CMD_OFS, 32'h1);
    t0 = cyc;
    at_tick(0, 1'b1, 20);
    chk(chan_on[1], 1'b0);
    rd(`OTS_STATUS_OFS, 32'h1);
    // coupled ch0 and ch1, offset below the largest latency
    wr(`OTS_CTRL_OFS, 32'h1);
    wr(`OTS_CHSEL_OFS, 32'h3);
    wr(`OTS_OFFSET_OFS, 32'h1E);
    rd(`OTS_OFFSET_OFS, 32'h1E);
    wr(`OTS_ONDLY_BASE, 32'hA);
    wr(`OTS_ONDLY_BASE + 8'h04, 32'h2);
    wr(`OTS_OFFDLY_BASE, 32'h3);
    wr(`OTS_CMD_OFS, 32'h10);
    t0 = cyc;
    at_tick(0, 1'b0, 3);
    wr(`OTS_CMD_OFS, 32'h2);
    t0 = cyc;
    rd(`OTS_STATUS_OFS, 32'h30);
    at_tick(1, 1'b1, 32);
    at_tick(0, 1'b1, 40);
    chk(chan_on[2], 1'b0);
    chk(on_falls, 8'h1);
    // far frame pulls the off line low
    @(posedge sys_clk_i);
    pull_off <= 1'b1;
    @(posedge sys_clk_i);
    pull_off <= 1'b0;
    t0 = cyc;
    at_tick(0, 1'b0, 3);
    chk(chan_on[1], 1'b0);
    // zero offset: each coupled channel waits its own latency
    wr(`OTS_OFFSET_OFS, 32'h0);
    wr(`OTS_CMD_OFS, 32'h1);
    t0 = cyc;
    at_tick(1, 1'b1, 27);
    at_tick(0, 1'b1, 28);
    finish_test;
  end
endmodule // testbench
